// ===== pkg/gpl_defs.svh
// Constants for the port 8 / port 9 pin block with LCD segment sharing
`ifndef GPL_DEFS_SVH
`define GPL_DEFS_SVH

// Bus geometry: register index times four is the byte address
`define GPL_ADDR_W 18
`define GPL_IDX_W 16

// Register indices
`define GPL_IDX_P8_DATA 16'hFFDB
`define GPL_IDX_P9_DATA 16'hFFDC
`define GPL_IDX_P8_DIR 16'hFFEB
`define GPL_IDX_P9_DIR 16'hFFEC
`define GPL_IDX_LCD_CTRL 16'hFFF0

// Reset values
`define GPL_RST_DATA 8'h00
`define GPL_RST_DIR 8'h00
`define GPL_RST_LCD_CTRL 8'h00

// Value returned by a read of a write-only register
`define GPL_WO_READ 8'hFF

// Field positions in the LCD port control register
`define GPL_SEL_LSB 0
`define GPL_SEL_MSB 3
`define GPL_EXT_SEL_BIT 7

`endif

// ===== pkg/gpl_pkg.sv
// Types shared by the port 8 / port 9 pin block
package gpl_pkg;

  // Chip operating mode as reported by the system controller
  typedef enum logic [2:0] {
    GPL_PM_ACTIVE = 3'h0,
    GPL_PM_SUBACTIVE = 3'h1,
    GPL_PM_SLEEP = 3'h2,
    GPL_PM_SUBSLEEP = 3'h3,
    GPL_PM_WATCH = 3'h4,
    GPL_PM_STANDBY = 3'h5
  } gpl_pwr_mode_t;

endpackage : gpl_pkg

// ===== verilog/gpl_pin.sv
// One shared pin cell: input synchroniser and registered pin drive
`timescale 1ns/10ps
`default_nettype none

module gpl_pin
  import gpl_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic hiz_i, // Float the pin (standby, illegal mode)
  input wire logic hold_i, // Freeze the pin (sleep, subsleep, watch)
  input wire logic gpio_i, // Pin is general I/O
  input wire logic dir_i, // Direction bit, 1 = output
  input wire logic dat_i, // Data latch bit
  input wire logic alt_i, // Segment or external driver value
  input wire logic pin_i, // Pin level from the pad
  output logic pin_o, // Value driven onto the pad
  output logic oe_o, // Pad driver enable
  output logic lvl_o // Synchronised pin level
);

  logic meta_q; // First synchroniser stage, read only by lvl_q
  logic lvl_q; // Second synchroniser stage
  logic out_q; // Registered pad value
  logic oe_q; // Registered pad enable
  logic drv_d; // Next pad enable
  logic out_d; // Next pad value

  // Alternate functions always drive; general I/O follows the direction bit
  assign drv_d = gpio_i ? dir_i : 1'b1;
  assign out_d = gpio_i ? dat_i : alt_i;

  // Pad level crosses in from outside, so two flops before any use
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= 1'b0;
      lvl_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_i;
      lvl_q <= meta_q;
    end
  end

  // Pad drive: floats in reset and standby, frozen in the sleep modes
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      // Reset floats the pad
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (hiz_i)
    begin
      // Keep the value so nothing toggles when the driver returns
      oe_q <= 1'b0;
    end
    else if (!hold_i)
    begin
      // Hold keeps both flops, so the pad retains its state
      out_q <= out_d;
      oe_q <= drv_d;
    end
  end

  assign pin_o = out_q;
  assign oe_o = oe_q;
  assign lvl_o = lvl_q;

endmodule : gpl_pin

`default_nettype wire

// ===== verilog/gpl_top.sv
// Port 8 / port 9 general I/O with LCD segment and driver pin sharing
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "gpl_defs.svh"

module gpl_top
  import gpl_pkg::*;
(
  input wire logic CLK_I, // System clock, 125 MHz
  input wire logic RST_N_I, // Synchronous reset, active low
  input wire logic PSEL_I, // APB select
  input wire logic PENABLE_I, // APB enable
  input wire logic PWRITE_I, // APB direction, 1 = write
  input wire logic [`GPL_ADDR_W-1:0] PADDR_I, // APB byte address
  input wire logic [31:0] PWDATA_I, // APB write data
  output logic [31:0] PRDATA_O, // APB read data
  output logic PREADY_O, // APB ready
  output logic PSLVERR_O, // APB error, unmapped address
  input wire logic [2:0] PWR_MODE_I, // Chip operating mode
  input wire logic [7:0] SEG_P8_I, // Segment drive for port 8 pins
  input wire logic [7:0] SEG_P9_I, // Segment drive for port 9 pins
  input wire logic EXT_FIRST_CLK_I, // External driver first clock
  input wire logic EXT_SECOND_CLK_I, // External driver second clock
  input wire logic EXT_DATA_I, // External driver serial data
  input wire logic EXT_FRAME_I, // External driver alternating frame
  input wire logic [7:0] P8_PIN_I, // Port 8 pad levels
  output logic [7:0] P8_PIN_O, // Port 8 pad drive values
  output logic [7:0] P8_OE_O, // Port 8 pad enables
  input wire logic [7:0] P9_PIN_I, // Port 9 pad levels
  output logic [7:0] P9_PIN_O, // Port 9 pad drive values
  output logic [7:0] P9_OE_O // Port 9 pad enables
);

  // Software-visible state
  logic [7:0] p8_dat_q; // Port 8 data latch
  logic [7:0] p8_dir_q; // Port 8 direction
  logic [7:0] p9_dat_q; // Port 9 data latch
  logic [7:0] p9_dir_q; // Port 9 direction
  logic [7:0] lcd_ctrl_q; // LCD port control register

  // Bus answer flops
  logic [31:0] prdata_q; // Read word
  logic pready_q; // Ready during the access phase
  logic pslverr_q; // Error during the access phase

  // Decode wires
  logic [`GPL_IDX_W-1:0] idx_w; // Register index from the byte address
  logic aligned_w; // Address is word aligned
  logic hit_p8_dat_w; // Port 8 data latch selected
  logic hit_p9_dat_w; // Port 9 data latch selected
  logic hit_p8_dir_w; // Port 8 direction selected
  logic hit_p9_dir_w; // Port 9 direction selected
  logic hit_lcd_w; // LCD control selected
  logic mapped_w; // Any register selected
  logic setup_w; // Setup phase of a transfer
  logic wr_en_w; // Write completes at this edge
  logic [7:0] rd_byte_w; // Low byte of the read answer
  logic [31:0] rd_word_w; // Read answer, upper bits zero

  // Mux wires
  logic [3:0] seg_sel_w; // Segment select field
  logic ext_sel_w; // External driver select
  logic p8_seg_w; // Port 8 pins carry segments
  logic p9_seg_w; // Port 9 pins carry segments
  logic [7:0] p8_gpio_w; // Port 8 pins in general I/O
  logic [7:0] p9_gpio_w; // Port 9 pins in general I/O
  logic [7:0] p9_alt_w; // Port 9 alternate drive values
  logic hiz_w; // Float all pins
  logic hold_w; // Freeze all pins
  logic run_w; // Pins follow the settings

  // Pin cell bundles, port 9 in the upper byte
  logic [15:0] gpio_w; // General I/O per pin
  logic [15:0] dir_w; // Direction per pin
  logic [15:0] dat_w; // Latch bit per pin
  logic [15:0] alt_w; // Alternate value per pin
  logic [15:0] pad_in_w; // Pad levels per pin
  logic [15:0] pad_out_w; // Pad values from the cells
  logic [15:0] pad_oe_w; // Pad enables from the cells
  logic [15:0] lvl_w; // Synchronised levels from the cells
  logic [7:0] p8_lvl_w; // Port 8 synchronised levels
  logic [7:0] p9_lvl_w; // Port 9 synchronised levels

  // Address decode: printed offsets are word indices
  assign idx_w = PADDR_I[`GPL_ADDR_W-1:2];
  assign aligned_w = (PADDR_I[1:0] == 2'h0);
  assign hit_p8_dat_w = aligned_w && (idx_w == `GPL_IDX_P8_DATA);
  assign hit_p9_dat_w = aligned_w && (idx_w == `GPL_IDX_P9_DATA);
  assign hit_p8_dir_w = aligned_w && (idx_w == `GPL_IDX_P8_DIR);
  assign hit_p9_dir_w = aligned_w && (idx_w == `GPL_IDX_P9_DIR);
  assign hit_lcd_w = aligned_w && (idx_w == `GPL_IDX_LCD_CTRL);
  assign mapped_w = hit_p8_dat_w | hit_p9_dat_w | hit_p8_dir_w
                  | hit_p9_dir_w | hit_lcd_w;

  // Transfer phases; a write lands only on the completing edge
  assign setup_w = PSEL_I && !PENABLE_I;
  assign wr_en_w = PSEL_I && PENABLE_I && PWRITE_I && pready_q && mapped_w;

  // Synchronised levels per port
  assign p8_lvl_w = lvl_w[7:0];
  assign p9_lvl_w = lvl_w[15:8];

  // Read mux: outputs show the latch, inputs show the pad
  assign rd_byte_w =
    hit_p8_dat_w ? ((p8_dir_q & p8_dat_q) | (~p8_dir_q & p8_lvl_w)) :
    hit_p9_dat_w ? ((p9_dir_q & p9_dat_q) | (~p9_dir_q & p9_lvl_w)) :
    (hit_p8_dir_w || hit_p9_dir_w) ? `GPL_WO_READ :
    hit_lcd_w ? lcd_ctrl_q : 8'h00;
  assign rd_word_w = {24'h000000, rd_byte_w};

  // Bus answer: sampled in setup, ready for exactly one access cycle
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else if (setup_w)
    begin
      // Writes read back zero; any unmapped access, read or write, also flags an error
      prdata_q <= PWRITE_I ? 32'h00000000 : rd_word_w;
      pready_q <= 1'b1;
      pslverr_q <= !mapped_w;
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Port 8 registers
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      p8_dat_q <= `GPL_RST_DATA;
      p8_dir_q <= `GPL_RST_DIR;
    end
    else if (wr_en_w)
    begin
      if (hit_p8_dat_w)
        p8_dat_q <= PWDATA_I[7:0];
      if (hit_p8_dir_w)
        p8_dir_q <= PWDATA_I[7:0];
    end
  end

  // Port 9 registers
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      p9_dat_q <= `GPL_RST_DATA;
      p9_dir_q <= `GPL_RST_DIR;
    end
    else if (wr_en_w)
    begin
      if (hit_p9_dat_w)
        p9_dat_q <= PWDATA_I[7:0];
      if (hit_p9_dir_w)
        p9_dir_q <= PWDATA_I[7:0];
    end
  end

  // LCD port control: segment select and external driver select
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      lcd_ctrl_q <= `GPL_RST_LCD_CTRL;
    else if (wr_en_w && hit_lcd_w)
      lcd_ctrl_q <= PWDATA_I[7:0];
  end

  // Pin function selection
  assign seg_sel_w = lcd_ctrl_q[`GPL_SEL_MSB:`GPL_SEL_LSB];
  assign ext_sel_w = lcd_ctrl_q[`GPL_EXT_SEL_BIT];
  assign p8_seg_w = |seg_sel_w[3:1];
  assign p9_seg_w = (seg_sel_w != 4'h0);
  assign p8_gpio_w = {8{!p8_seg_w}};
  // Upper four port 9 pins also yield to the external driver
  assign p9_gpio_w = {{4{!p9_seg_w && !ext_sel_w}}, {4{!p9_seg_w}}};
  assign p9_alt_w[7] = ext_sel_w ? EXT_FIRST_CLK_I : SEG_P9_I[7];
  assign p9_alt_w[6] = ext_sel_w ? EXT_SECOND_CLK_I : SEG_P9_I[6];
  assign p9_alt_w[5] = ext_sel_w ? EXT_DATA_I : SEG_P9_I[5];
  assign p9_alt_w[4] = ext_sel_w ? EXT_FRAME_I : SEG_P9_I[4];
  assign p9_alt_w[3:0] = SEG_P9_I[3:0];

  // Operating mode: unknown codes float the pins as the safe choice
  assign run_w = (PWR_MODE_I == GPL_PM_ACTIVE) || (PWR_MODE_I == GPL_PM_SUBACTIVE);
  assign hold_w = (PWR_MODE_I == GPL_PM_SLEEP) || (PWR_MODE_I == GPL_PM_SUBSLEEP)
               || (PWR_MODE_I == GPL_PM_WATCH);
  assign hiz_w = !run_w && !hold_w;

  // Bundle both ports for the pin cells
  assign gpio_w = {p9_gpio_w, p8_gpio_w};
  assign dir_w = {p9_dir_q, p8_dir_q};
  assign dat_w = {p9_dat_q, p8_dat_q};
  assign alt_w = {p9_alt_w, SEG_P8_I};
  assign pad_in_w = {P9_PIN_I, P8_PIN_I};

  // One cell per pad; each cell ends in the flops that drive the pad
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_pin
      gpl_pin u_pin (
        .clk_i (CLK_I),
        .rst_n_i (RST_N_I),
        .hiz_i (hiz_w),
        .hold_i (hold_w),
        .gpio_i (gpio_w[gi]),
        .dir_i (dir_w[gi]),
        .dat_i (dat_w[gi]),
        .alt_i (alt_w[gi]),
        .pin_i (pad_in_w[gi]),
        .pin_o (pad_out_w[gi]),
        .oe_o (pad_oe_w[gi]),
        .lvl_o (lvl_w[gi])
      );
    end
  endgenerate

  // Outputs come straight from flops
  assign P8_PIN_O = pad_out_w[7:0];
  assign P8_OE_O = pad_oe_w[7:0];
  assign P9_PIN_O = pad_out_w[15:8];
  assign P9_OE_O = pad_oe_w[15:8];
  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;

  // Checks on the block's own behaviour
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  // Registers come out of reset cleared
  property p_rst_clear;
    $past(!RST_N_I) |-> (p8_dir_q == 8'h00) && (p8_dat_q == 8'h00)
                     && (p9_dir_q == 8'h00) && (p9_dat_q == 8'h00);
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("registers not cleared after reset");

  // Direction registers read back as all ones
  property p_dir_read;
    (setup_w && !PWRITE_I && (hit_p8_dir_w || hit_p9_dir_w))
      |=> PREADY_O && (PRDATA_O == 32'h000000FF) && !PSLVERR_O;
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction register read not all ones");

  // Port 8 segment mode drives the segment values
  property p_p8_seg;
    (run_w && p8_seg_w) |=> (P8_OE_O == 8'hFF) && (P8_PIN_O == $past(SEG_P8_I));
  endproperty
  a_p8_seg: assert property (p_p8_seg)
    else $error("port 8 segment drive wrong");

  // Standby floats every pad
  property p_standby_hiz;
    hiz_w |=> (P8_OE_O == 8'h00) && (P9_OE_O == 8'h00);
  endproperty
  a_standby_hiz: assert property (p_standby_hiz)
    else $error("pads driven in standby");

  // Sleep modes keep the pads as they were
  property p_hold;
    hold_w |=> $stable(P8_PIN_O) && $stable(P8_OE_O)
            && $stable(P9_PIN_O) && $stable(P9_OE_O);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pads changed while held");

  // Port 9 read merges latch and pad by direction
  property p_p9_read;
    (setup_w && !PWRITE_I && hit_p9_dat_w)
      |=> PRDATA_O[7:0] == (($past(p9_dir_q) & $past(p9_dat_q))
                          | (~$past(p9_dir_q) & $past(p9_lvl_w)));
  endproperty
  a_p9_read: assert property (p_p9_read)
    else $error("port 9 read value wrong");

  // A completed write reaches the port 8 direction register
  property p_p8_dir_wr;
    (wr_en_w && hit_p8_dir_w) |=> p8_dir_q == $past(PWDATA_I[7:0]);
  endproperty
  a_p8_dir_wr: assert property (p_p8_dir_wr)
    else $error("port 8 direction write lost");

  // General I/O port 9 pins follow direction and latch
  property p_p9_gpio;
    (run_w && !p9_seg_w && !ext_sel_w)
      |=> (P9_OE_O == $past(p9_dir_q)) && (P9_PIN_O == $past(p9_dat_q));
  endproperty
  a_p9_gpio: assert property (p_p9_gpio)
    else $error("port 9 general I/O drive wrong");

  // External driver select puts the driver signals on pins 7 to 4
  property p_ext_drv;
    (run_w && ext_sel_w) |=> (P9_OE_O[7:4] == 4'hF)
      && (P9_PIN_O[7:4] == $past({EXT_FIRST_CLK_I, EXT_SECOND_CLK_I, EXT_DATA_I, EXT_FRAME_I}));
  endproperty
  a_ext_drv: assert property (p_ext_drv)
    else $error("external driver signals not on port 9");

  // Segment mode on port 9 ignores the general I/O settings
  property p_p9_seg;
    (run_w && p9_seg_w && !ext_sel_w)
      |=> (P9_OE_O == 8'hFF) && (P9_PIN_O == $past(SEG_P9_I));
  endproperty
  a_p9_seg: assert property (p_p9_seg)
    else $error("port 9 segment drive wrong");

  // Port 8 read merges latch and pad by direction
  property p_p8_read;
    (setup_w && !PWRITE_I && hit_p8_dat_w)
      |=> PRDATA_O[7:0] == (($past(p8_dir_q) & $past(p8_dat_q))
                          | (~$past(p8_dir_q) & $past(p8_lvl_w)));
  endproperty
  a_p8_read: assert property (p_p8_read)
    else $error("port 8 read value wrong");

  // General I/O port 8 pins follow direction and latch
  property p_p8_gpio;
    (run_w && !p8_seg_w)
      |=> (P8_OE_O == $past(p8_dir_q)) && (P8_PIN_O == $past(p8_dat_q));
  endproperty
  a_p8_gpio: assert property (p_p8_gpio)
    else $error("port 8 general I/O drive wrong");

  // A completed write reaches the port 9 direction register
  property p_p9_dir_wr;
    (wr_en_w && hit_p9_dir_w) |=> p9_dir_q == $past(PWDATA_I[7:0]);
  endproperty
  a_p9_dir_wr: assert property (p_p9_dir_wr)
    else $error("port 9 direction write lost");

  // Main scenarios
  c_p8_seg: cover property (run_w && p8_seg_w);
  c_ext_drv: cover property (run_w && ext_sel_w);
  c_gpio_out: cover property (run_w && !p9_seg_w && (p9_dir_q != 8'h00));
  c_hold: cover property (hold_w ##1 run_w);

endmodule : gpl_top

`default_nettype wire

// ===== verification/gpl_board.sv
// Board side of the shared pads: external levels meet the pad drivers
`timescale 1ns/10ps
`default_nettype none

module gpl_board (
  input wire logic [7:0] oe_i, // Pad enables from the block
  input wire logic [7:0] drv_i, // Pad drive values from the block
  input wire logic [7:0] ext_i, // Levels the board applies to inputs
  output logic [7:0] lvl_o // Resolved pad level
);
  // A driven pad wins; an undriven pad shows the board's own level
  assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : gpl_board

`default_nettype wire

// ===== verification/gpl_top_bench.sv
// Self-checking bench for the port 8 / port 9 pin block
`timescale 1ns/10ps
`default_nettype none
`include "gpl_defs.svh"

module gpl_top_bench
  import gpl_pkg::*;
;
  logic clk = 1'b0; // System clock
  logic rst_n = 1'b0; // Reset, active low
  logic psel = 1'b0; // Bus select
  logic pen = 1'b0; // Bus enable
  logic pwr = 1'b0; // Bus direction
  logic [17:0] paddr = 18'h0; // Bus address
  logic [31:0] pwdata = 32'h0; // Bus write data
  logic [2:0] mode = 3'h0; // Operating mode, active
  logic [7:0] seg8 = 8'h3C; // Segment values, port 8
  logic [7:0] seg9 = 8'hC3; // Segment values, port 9
  logic [7:0] ext8 = 8'h96; // Board levels, port 8
  logic [7:0] ext9 = 8'h69; // Board levels, port 9
  logic [3:0] xd = 4'hA; // External driver signals, pin 7 down to 4
  logic [7:0] d8 = 8'h0; // Mirror of port 8 direction
  logic [7:0] l8 = 8'h0; // Mirror of port 8 latch
  logic [7:0] d9 = 8'h0; // Mirror of port 9 direction
  logic [7:0] l9 = 8'h0; // Mirror of port 9 latch
  logic [7:0] lc = 8'h0; // Mirror of LCD port control
  wire [31:0] prdata; // Bus read data
  wire pready; // Bus ready
  wire pslverr; // Bus error
  wire [7:0] p8i, p8o, p8e, p9i, p9o, p9e; // Pad nets
  int err_count = 0; // Mismatches
  int checks = 0; // Comparisons

  // Free-running clock, 8 ns period
  always #4 clk = ~clk;

  gpl_top i_dut (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .PWR_MODE_I(mode), .SEG_P8_I(seg8),
    .SEG_P9_I(seg9), .EXT_FIRST_CLK_I(xd[3]), .EXT_SECOND_CLK_I(xd[2]), .EXT_DATA_I(xd[1]),
    .EXT_FRAME_I(xd[0]), .P8_PIN_I(p8i), .P8_PIN_O(p8o), .P8_OE_O(p8e),
    .P9_PIN_I(p9i), .P9_PIN_O(p9o), .P9_OE_O(p9e));
  gpl_board i_brd8 (.oe_i(p8e), .drv_i(p8o), .ext_i(ext8), .lvl_o(p8i));
  gpl_board i_brd9 (.oe_i(p9e), .drv_i(p9o), .ext_i(ext9), .lvl_o(p9i));

  // Counts and verdict; the only place the run ends
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One bus transfer; request held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    // A slave that never answers ends the run
    if (n == 16)
    begin
      err_count++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // Write without a check
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] v;
    logic e;
    apb(1'b1, idx, d, v, e);
  endtask : wr

  // Read one register and compare it
  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
    logic [31:0] v;
    logic e;
    apb(1'b0, idx, 8'h00, v, e);
    chk(v, {24'h0, exp});
    chk({31'h0, e}, 32'h0);
  endtask : rdc

  // Pad enables and driven values from the mirrors, active mode
  task automatic pins();
    logic [7:0] e8, v8, e9, v9;
    // Look at the pads away from the edge that launches them
    @(negedge clk);
    e8 = (lc[3:1] != 3'h0) ? 8'hFF : d8;
    v8 = (lc[3:1] != 3'h0) ? seg8 : (l8 & d8);
    e9 = (lc[3:0] != 4'h0) ? 8'hFF : d9;
    v9 = (lc[3:0] != 4'h0) ? seg9 : (l9 & d9);
    // External driver select owns the upper four pins of port 9
    if (lc[7])
    begin
      e9[7:4] = 4'hF;
      v9[7:4] = xd;
    end
    chk({24'h0, p8e}, {24'h0, e8});
    chk({24'h0, p8o & p8e}, {24'h0, v8});
    chk({24'h0, p9e}, {24'h0, e9});
    chk({24'h0, p9o & p9e}, {24'h0, v9});
  endtask : pins

  // Reset values, write-only reads, latches cleared
  task automatic sc_reset();
    pins();
    rdc(`GPL_IDX_P8_DIR, 8'hFF);
    rdc(`GPL_IDX_P9_DIR, 8'hFF);
    rdc(`GPL_IDX_P8_DATA, ext8);
    rdc(`GPL_IDX_P9_DATA, ext9);
    d8 = 8'hFF;
    d9 = 8'hFF;
    wr(`GPL_IDX_P8_DIR, d8);
    wr(`GPL_IDX_P9_DIR, d9);
    rdc(`GPL_IDX_P8_DATA, 8'h00);
    rdc(`GPL_IDX_P9_DATA, 8'h00);
    pins();
  endtask : sc_reset

  // Mixed directions: read merges latch and live pad level
  task automatic sc_gpio();
    l8 = 8'hA5;
    d8 = 8'hF0;
    l9 = 8'h5A;
    d9 = 8'h0F;
    wr(`GPL_IDX_P8_DATA, l8);
    wr(`GPL_IDX_P8_DIR, d8);
    wr(`GPL_IDX_P9_DATA, l9);
    wr(`GPL_IDX_P9_DIR, d9);
    repeat (4) @(posedge clk);
    pins();
    rdc(`GPL_IDX_P8_DATA, (l8 & d8) | (ext8 & ~d8));
    rdc(`GPL_IDX_P9_DATA, (l9 & d9) | (ext9 & ~d9));
    rdc(`GPL_IDX_P8_DIR, 8'hFF);
  endtask : sc_gpio

  // Every segment select code, with and without the external driver
  task automatic sc_mux();
    for (int i = 0; i < 32; i++)
    begin
      xd <= i[3:0] ^ 4'h5;
      lc = {i[4], 3'h0, i[3:0]};
      wr(`GPL_IDX_LCD_CTRL, lc);
      repeat (2) @(posedge clk);
      pins();
    end
  endtask : sc_mux

  // Hold modes freeze pads, standby floats them
  task automatic sc_mode();
    logic [7:0] s8, s9;
    for (int m = 2; m < 5; m++)
    begin
      mode <= m[2:0];
      repeat (2) @(posedge clk);
      s8 = p8o;
      s9 = p9o;
      seg8 <= ~seg8;
      seg9 <= ~seg9;
      repeat (3) @(posedge clk);
      chk({24'h0, p8o}, {24'h0, s8});
      chk({24'h0, p9o}, {24'h0, s9});
    end
    mode <= GPL_PM_STANDBY;
    repeat (3) @(posedge clk);
    chk({16'h0, p8e, p9e}, 32'h0);
    mode <= GPL_PM_SUBACTIVE;
    repeat (3) @(posedge clk);
    pins();
  endtask : sc_mode

  // Unmapped place answers with an error and reads zero
  task automatic sc_err();
    logic [31:0] v;
    logic e;
    apb(1'b0, 16'h0000, 8'h00, v, e);
    chk({31'h0, e}, 32'h1);
    chk(v, 32'h0);
    apb(1'b1, 16'h0001, 8'h55, v, e);
    chk({31'h0, e}, 32'h1);
  endtask : sc_err

  // Reset in mid-run floats driven pads, then clears every register
  task automatic sc_rerun();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({16'h0, p8e, p9e}, 32'h0);
    rst_n <= 1'b1;
    d8 = 8'h00;
    l8 = 8'h00;
    d9 = 8'h00;
    l9 = 8'h00;
    lc = 8'h00;
    repeat (3) @(posedge clk);
    sc_reset();
  endtask : sc_rerun

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    sc_reset();
    sc_gpio();
    sc_mux();
    sc_mode();
    sc_err();
    sc_rerun();
    test_done();
  end
endmodule : gpl_top_bench

`default_nettype wire
